// ===== rtl/alu_pkg.sv
// Shared types and constants of the CPU arithmetic, logic and shift unit.
// Assumes a single clock domain and operands already read from the register file.
package alu_pkg;

  // Operation codes presented by the instruction decoder.
  typedef enum logic [4:0] {
    op_add, op_sub, add_with_carry_op, subtract_with_carry_op,
    count_up_op, count_down_op, word_step_add_op, word_step_subtract_op,
    bcd_adjust_after_add, bcd_adjust_after_sub,
    unsigned_multiply_8x8, unsigned_divide_16by8,
    compare_op, twos_complement_op,
    op_and, op_or, op_xor, op_not,
    arith_shift_left, arith_shift_right, logic_shift_left, logic_shift_right,
    rotate_left, rotate_right, rotate_left_through_carry, rotate_right_through_carry
  } alu_op_t;

  // Flag positions inside the condition flags register.
  localparam int FLAG_C_POS = 0;
  localparam int FLAG_V_POS = 1;
  localparam int FLAG_Z_POS = 2;
  localparam int FLAG_N_POS = 3;
  localparam int FLAG_H_POS = 5;

  // Register map of the flag port and values after reset.
  localparam logic [3:0] FLAGS_ADDR  = 4'h0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Decimal adjust constants.
  localparam logic [7:0] BCD_LO_FIX  = 8'h06;
  localparam logic [7:0] BCD_HI_FIX  = 8'h60;
  localparam logic [3:0] BCD_NIB_MAX = 4'h9;
  localparam logic [7:0] BCD_MAX     = 8'h99;

  // Result of the shared adder.
  typedef struct packed {
    logic [15:0] res;
    logic        c;
    logic        h;
    logic        v;
  } arith_t;

  // Condition flags held by the unit.
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
    logic h;
  } flags_t;

endpackage

// ===== rtl/cpu_arith_logic_shift_unit.sv
// Arithmetic, logic and shift datapath with its condition flags register.
// Assumes the decoder supplies operands and one-cycle start pulses; results return one cycle later.
`timescale 1ns/1ps
module cpu_arith_logic_shift_unit
  import alu_pkg::*;
#(
  parameter int BUS_AW = 4
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic              start,
  input  wire alu_op_t           op,
  input  wire logic              word_size,
  input  wire logic              use_imm,
  input  wire logic              step_two,
  input  wire logic [15:0]       dest_register,
  input  wire logic [15:0]       source_register,
  input  wire logic [7:0]        imm,
  input  wire logic [BUS_AW-1:0] bus_addr,
  input  wire logic [7:0]        bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic [7:0]             bus_rdata,
  output logic                   done,
  output logic                   result_we,
  output logic                   result_word,
  output logic                   refused,
  output logic [15:0]            result,
  output logic [7:0]             condition_flags_register
);

  // The flag address must fit the bus.
  if (BUS_AW < 4) begin : g_bad_aw
    $error("BUS_AW must be at least 4");
  end

  // Whole state of the unit.
  typedef struct packed {
    logic        done;
    logic        we;
    logic        word;
    logic        refused;
    logic [15:0] result;
    flags_t      flags;
    logic [7:0]  rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // Shared adder; subtract inverts the addend and reports borrow as carry.
  function automatic arith_t add_core(input logic [15:0] a, input logic [15:0] b,
                                      input logic cin, input logic sub, input logic word);
    arith_t      r;
    logic [15:0] bb;
    logic        ci;
    logic [16:0] s17;
    logic [12:0] s13;
    logic [8:0]  s9;
    logic [4:0]  s5;
    bb  = sub ? ~b : b;
    ci  = cin ^ sub;
    s17 = {1'b0, a} + {1'b0, bb} + {16'h0000, ci};
    s13 = {1'b0, a[11:0]} + {1'b0, bb[11:0]} + {12'h000, ci};
    s9  = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, ci};
    s5  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    if (word) begin
      r.res = s17[15:0];
      r.c   = s17[16] ^ sub;
      r.h   = s13[12] ^ sub;
      r.v   = (a[15] == bb[15]) && (s17[15] != a[15]);
    end else begin
      r.res = {8'h00, s9[7:0]};
      r.c   = s9[8] ^ sub;
      r.h   = s5[4] ^ sub;
      r.v   = (a[7] == bb[7]) && (s9[7] != a[7]);
    end
    return r;
  endfunction

  // Sign of a result of the given size.
  function automatic logic sign_of(input logic [15:0] r, input logic word);
    return word ? r[15] : r[7];
  endfunction

  // Zero test of a result of the given size.
  function automatic logic zero_of(input logic [15:0] r, input logic word);
    return word ? (r == 16'h0000) : (r[7:0] == 8'h00);
  endfunction

  // Immediate data is only legal for the byte forms that the decoder can encode.
  function automatic logic imm_ok(input alu_op_t o, input logic word);
    case (o)
      op_add, compare_op:                        return !word;
      add_with_carry_op, subtract_with_carry_op: return 1'b1;
      op_and, op_or, op_xor:                     return 1'b1;
      default:                                   return 1'b0;
    endcase
  endfunction

  // Word size is only meaningful for these operations.
  function automatic logic word_ok(input alu_op_t o);
    case (o)
      op_add, op_sub, compare_op:                  return 1'b1;
      word_step_add_op, word_step_subtract_op:     return 1'b1;
      unsigned_multiply_8x8, unsigned_divide_16by8: return 1'b1;
      default:                                     return 1'b0;
    endcase
  endfunction

  // Operands and shared arithmetic results.
  logic [7:0]  a8;
  logic [7:0]  b8;
  logic [15:0] b16;
  logic        is_word;
  logic        legal;
  arith_t      ar;
  logic [7:0]  sh;
  logic        sh_out;
  logic [7:0]  bcd;
  logic        bcd_c;
  logic [15:0] quot;
  logic [15:0] rem;

  // Operand selection; word forms always come from registers.
  always_comb begin
    a8      = dest_register[7:0];
    b8      = use_imm ? imm : source_register[7:0];
    b16     = use_imm ? {8'h00, imm} : source_register;
    is_word = word_size && (op == op_add || op == op_sub || op == compare_op);
    legal   = (!use_imm || imm_ok(op, word_size)) && (!word_size || word_ok(op));
  end

  // One adder serves every add, subtract, compare, count and negate form except the word steps.
  always_comb begin
    case (op)
      op_add:                 ar = add_core(dest_register, b16, 1'b0, 1'b0, is_word);
      op_sub, compare_op:     ar = add_core(dest_register, b16, 1'b0, 1'b1, is_word);
      add_with_carry_op:      ar = add_core({8'h00, a8}, {8'h00, b8}, st.flags.c, 1'b0, 1'b0);
      subtract_with_carry_op: ar = add_core({8'h00, a8}, {8'h00, b8}, st.flags.c, 1'b1, 1'b0);
      count_up_op:            ar = add_core({8'h00, a8}, 16'h0001, 1'b0, 1'b0, 1'b0);
      count_down_op:          ar = add_core({8'h00, a8}, 16'h0001, 1'b0, 1'b1, 1'b0);
      twos_complement_op:     ar = add_core(16'h0000, {8'h00, a8}, 1'b0, 1'b1, 1'b0);
      default:                ar = add_core(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
    endcase
  end

  // Single-bit shifts and rotates; the bit leaving the byte is kept for carry.
  always_comb begin
    sh     = a8;
    sh_out = 1'b0;
    case (op)
      arith_shift_left, logic_shift_left: begin
        sh     = {a8[6:0], 1'b0};
        sh_out = a8[7];
      end
      arith_shift_right: begin
        sh     = {a8[7], a8[7:1]};
        sh_out = a8[0];
      end
      logic_shift_right: begin
        sh     = {1'b0, a8[7:1]};
        sh_out = a8[0];
      end
      rotate_left: begin
        sh     = {a8[6:0], a8[7]};
        sh_out = a8[7];
      end
      rotate_right: begin
        sh     = {a8[0], a8[7:1]};
        sh_out = a8[0];
      end
      rotate_left_through_carry: begin
        sh     = {a8[6:0], st.flags.c};
        sh_out = a8[7];
      end
      rotate_right_through_carry: begin
        sh     = {st.flags.c, a8[7:1]};
        sh_out = a8[0];
      end
      default: begin
        sh     = a8;
        sh_out = 1'b0;
      end
    endcase
  end

  // Decimal adjust from the half-carry and carry left by the previous byte operation.
  always_comb begin
    bcd   = a8;
    bcd_c = st.flags.c;
    if (op == bcd_adjust_after_add) begin
      if (st.flags.c || a8 > BCD_MAX) begin
        bcd   = bcd + BCD_HI_FIX;
        bcd_c = 1'b1;
      end
      if (st.flags.h || a8[3:0] > BCD_NIB_MAX) begin
        bcd = bcd + BCD_LO_FIX;
      end
    end else begin
      if (st.flags.c) begin
        bcd = bcd - BCD_HI_FIX;
      end
      if (st.flags.h) begin
        bcd = bcd - BCD_LO_FIX;
      end
    end
  end

  // Divider; a zero divisor is guarded so the operator never sees it.
  always_comb begin
    if (source_register[7:0] == 8'h00) begin
      quot = 16'hFFFF;
      rem  = dest_register;
    end else begin
      quot = dest_register / {8'h00, source_register[7:0]};
      rem  = dest_register % {8'h00, source_register[7:0]};
    end
  end

  // Next state: operation results, flags and the flag port.
  always_comb begin
    next_st         = st;
    next_st.done    = 1'b0;
    next_st.we      = 1'b0;
    next_st.refused = 1'b0;
    next_st.rdata   = 8'h00;
    // A software write to the flags comes first so a same-cycle operation overrides the flags that it updates.
    if (bus_wr && bus_addr == BUS_AW'(FLAGS_ADDR)) begin
      next_st.flags.c = bus_wdata[FLAG_C_POS];
      next_st.flags.v = bus_wdata[FLAG_V_POS];
      next_st.flags.z = bus_wdata[FLAG_Z_POS];
      next_st.flags.n = bus_wdata[FLAG_N_POS];
      next_st.flags.h = bus_wdata[FLAG_H_POS];
    end
    if (bus_rd && bus_addr == BUS_AW'(FLAGS_ADDR)) begin
      next_st.rdata = condition_flags_register;
    end
    if (start) begin
      next_st.done = 1'b1;
      next_st.word = is_word;
      if (!legal) begin
        next_st.refused = 1'b1;
      end else begin
        case (op)
          op_add, op_sub, compare_op, twos_complement_op: begin
            // Compare keeps the previous result, so only the flags report its outcome.
            if (op != compare_op) begin
              next_st.result = ar.res;
            end
            next_st.we      = (op != compare_op);
            next_st.flags.n = sign_of(ar.res, is_word);
            next_st.flags.z = zero_of(ar.res, is_word);
            next_st.flags.v = ar.v;
            next_st.flags.c = ar.c;
            next_st.flags.h = ar.h;
          end
          add_with_carry_op, subtract_with_carry_op: begin
            // Zero only stays set, so a multi-byte chain tests zero across all bytes.
            next_st.result  = ar.res;
            next_st.we      = 1'b1;
            next_st.flags.n = ar.res[7];
            next_st.flags.z = st.flags.z & zero_of(ar.res, 1'b0);
            next_st.flags.v = ar.v;
            next_st.flags.c = ar.c;
            next_st.flags.h = ar.h;
          end
          count_up_op, count_down_op: begin
            // Carry is left alone so counters can sit inside carry chains.
            next_st.result  = ar.res;
            next_st.we      = 1'b1;
            next_st.flags.n = ar.res[7];
            next_st.flags.z = zero_of(ar.res, 1'b0);
            next_st.flags.v = ar.v;
          end
          word_step_add_op: begin
            next_st.result = dest_register + (step_two ? 16'h0002 : 16'h0001);
            next_st.we     = 1'b1;
            next_st.word   = 1'b1;
          end
          word_step_subtract_op: begin
            next_st.result = dest_register - (step_two ? 16'h0002 : 16'h0001);
            next_st.we     = 1'b1;
            next_st.word   = 1'b1;
          end
          bcd_adjust_after_add, bcd_adjust_after_sub: begin
            next_st.result  = {8'h00, bcd};
            next_st.we      = 1'b1;
            next_st.flags.n = bcd[7];
            next_st.flags.z = (bcd == 8'h00);
            next_st.flags.c = bcd_c;
          end
          unsigned_multiply_8x8: begin
            next_st.result = {8'h00, a8} * {8'h00, source_register[7:0]};
            next_st.we     = 1'b1;
            next_st.word   = 1'b1;
          end
          unsigned_divide_16by8: begin
            // Remainder in the upper byte, quotient in the lower; a zero divisor writes nothing.
            if (source_register[7:0] != 8'h00) begin
              next_st.result = {rem[7:0], quot[7:0]};
            end
            next_st.we      = (source_register[7:0] != 8'h00);
            next_st.word    = 1'b1;
            next_st.flags.n = source_register[7];
            next_st.flags.z = (source_register[7:0] == 8'h00);
          end
          op_and, op_or, op_xor, op_not: begin
            case (op)
              op_and:  next_st.result = {8'h00, a8 & b8};
              op_or:   next_st.result = {8'h00, a8 | b8};
              op_xor:  next_st.result = {8'h00, a8 ^ b8};
              default: next_st.result = {8'h00, ~a8};
            endcase
            next_st.we      = 1'b1;
            next_st.flags.n = next_st.result[7];
            next_st.flags.z = zero_of(next_st.result, 1'b0);
            next_st.flags.v = 1'b0;
          end
          default: begin
            next_st.result  = {8'h00, sh};
            next_st.we      = 1'b1;
            next_st.flags.n = sh[7];
            next_st.flags.z = (sh == 8'h00);
            next_st.flags.c = sh_out;
            next_st.flags.v = (op == arith_shift_left) ? (a8[7] ^ a8[6]) : 1'b0;
          end
        endcase
      end
    end
  end

  // Register the whole state; a low clock enable freezes everything except reset.
  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Outputs straight from state flip-flops.
  assign done        = st.done;
  assign result_we   = st.we;
  assign result_word = st.word;
  assign refused     = st.refused;
  assign result      = st.result;
  assign bus_rdata   = st.rdata;

  // Flag register image; unused bits read zero.
  always_comb begin
    condition_flags_register             = FLAGS_RESET;
    condition_flags_register[FLAG_C_POS] = st.flags.c;
    condition_flags_register[FLAG_V_POS] = st.flags.v;
    condition_flags_register[FLAG_Z_POS] = st.flags.z;
    condition_flags_register[FLAG_N_POS] = st.flags.n;
    condition_flags_register[FLAG_H_POS] = st.flags.h;
  end

endmodule // cpu_arith_logic_shift_unit

// ===== verification/wb_regfile_model.sv
// Writeback side of the register file that receives the unit's results.
// Assumes results are offered with a one-cycle write pulse on the unit clock.
`timescale 1ns/1ps
module wb_regfile_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        result_we,
  input  wire logic [15:0] result,
  output logic [15:0]      wb_value,
  output logic [15:0]      wb_count
);
  // Count writebacks so that refused or flag-only operations can be seen not to write.
  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_value <= 16'h0000;
      wb_count <= 16'h0000;
    end else if (result_we) begin
      wb_value <= result;
      wb_count <= wb_count + 16'h0001;
    end
  end
endmodule // wb_regfile_model

// ===== verification/alu_port_asserts.sv
// Concurrent checks on the ports of the arithmetic, logic and shift unit.
// Assumes one clock, synchronous active-high reset and the flag port at address zero.
`timescale 1ns/1ps
module alu_port_checker
  import alu_pkg::*;
#(
  parameter int BUS_AW = 4
) (
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              clk_en,
  input wire logic              start,
  input wire alu_op_t           op,
  input wire logic              word_size,
  input wire logic              use_imm,
  input wire logic [15:0]       dest_register,
  input wire logic [15:0]       source_register,
  input wire logic [7:0]        imm,
  input wire logic [BUS_AW-1:0] bus_addr,
  input wire logic              bus_rd,
  input wire logic [7:0]        bus_rdata,
  input wire logic              done,
  input wire logic              result_we,
  input wire logic              refused,
  input wire logic [15:0]       result,
  input wire logic [7:0]        condition_flags_register
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // A request is the start pulse taken with the clock enabled.
  sequence s_take;
    start && clk_en;
  endsequence
  sequence s_do(alu_op_t o);
    start && clk_en && op == o;
  endsequence

  // Answer timing: one cycle after a request, nothing without one.
  done_follows_start_a: assert property (s_take |=> done) else $error("done missing after start");
  quiet_when_idle_a: assert property (clk_en && !start |=> !done && !result_we && !refused)
    else $error("answer without request");
  // Illegal immediate forms are refused and never written back; compare writes no result.
  sub_imm_refused_a: assert property (s_do(op_sub) ##0 use_imm |=> refused && !result_we)
    else $error("immediate subtract accepted");
  word_imm_refused_a: assert property (s_take ##0 word_size && use_imm |=> refused && !result_we)
    else $error("immediate word form accepted");
  compare_no_write_a: assert property (s_do(compare_op) |=> !result_we && $stable(result))
    else $error("compare wrote a result");
  // Datapath results tied to the operands taken with the request.
  multiply_product_a: assert property (s_do(unsigned_multiply_8x8) ##0 !use_imm |=>
    result == 16'($past(dest_register[7:0])) * 16'($past(source_register[7:0]))) else $error("bad product");
  negate_value_a: assert property (s_do(twos_complement_op) ##0 !use_imm && !word_size |=>
    result == {8'h00, 8'(8'h00 - $past(dest_register[7:0]))}) else $error("bad negate");
  and_value_a: assert property (s_do(op_and) ##0 !word_size |=> result[7:0] ==
    ($past(dest_register[7:0]) & ($past(use_imm) ? $past(imm) : $past(source_register[7:0]))))
    else $error("bad and");
  rotate_carry_a: assert property (s_do(rotate_left) ##0 !use_imm && !word_size |=>
    condition_flags_register[FLAG_C_POS] == $past(dest_register[7])
    && result[7:0] == {$past(dest_register[6:0]), $past(dest_register[7])}) else $error("bad rotate");
  // Unmapped flag port reads return zero in the data cycle.
  unmapped_read_a: assert property (clk_en && bus_rd && bus_addr != '0 |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // alu_port_checker

bind cpu_arith_logic_shift_unit alu_port_checker #(.BUS_AW(BUS_AW)) u_chk (
  .mclk(mclk), .reset(reset), .clk_en(clk_en), .start(start), .op(op), .word_size(word_size),
  .use_imm(use_imm), .dest_register(dest_register), .source_register(source_register), .imm(imm),
  .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .done(done), .result_we(result_we),
  .refused(refused), .result(result), .condition_flags_register(condition_flags_register));

// ===== verification/tb.sv
// Self-checking bench for the arithmetic, logic and shift unit.
// Assumes a one-cycle answer to every start pulse and the flag register at address zero.
`timescale 1ns/1ps
module tb;
  import alu_pkg::*;
  logic        mclk, reset, clk_en, start, word_size, use_imm, step_two, bus_wr, bus_rd;
  logic        done, result_we, result_word, refused;
  alu_op_t     op;
  logic [15:0] dest_register, source_register, result, wb_value, wb_count, nwb;
  logic [7:0]  imm, bus_wdata, bus_rdata, condition_flags_register, q;
  logic [3:0]  bus_addr;
  int          err_count, tests_run;
  alu_op_t     sh_op[8] = '{arith_shift_left, arith_shift_right, logic_shift_left, logic_shift_right,
                            rotate_left, rotate_right, rotate_left_through_carry, rotate_right_through_carry};
  logic [7:0]  sh_in[8] = '{8'h81, 8'h81, 8'h81, 8'h81, 8'h81, 8'h81, 8'h01, 8'h01};
  logic [7:0]  sh_res[8] = '{8'h02, 8'hC0, 8'h02, 8'h40, 8'h03, 8'hC0, 8'h03, 8'h00};
  logic        sh_c[8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  alu_op_t     lg_op[4] = '{op_and, op_or, op_xor, op_not};
  logic [7:0]  lg_res[4] = '{8'h42, 8'hDB, 8'h99, 8'h3C};

  cpu_arith_logic_shift_unit u_dut (
    .mclk(mclk), .reset(reset), .clk_en(clk_en), .start(start), .op(op), .word_size(word_size),
    .use_imm(use_imm), .step_two(step_two), .dest_register(dest_register),
    .source_register(source_register), .imm(imm), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .done(done), .result_we(result_we),
    .result_word(result_word), .refused(refused), .result(result),
    .condition_flags_register(condition_flags_register));
  wb_regfile_model u_rf (.mclk(mclk), .reset(reset), .result_we(result_we), .result(result),
    .wb_value(wb_value), .wb_count(wb_count));

  // Free-running 50 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Compare one value and count it; unknowns never match.
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task wrap_up;
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One operation: request after an edge, then check the answer settled after the next edge.
  task go(input alu_op_t o, input logic w, input logic i, input logic [15:0] d, input logic [15:0] s,
          input logic [7:0] m, input logic [15:0] r, input logic we, input logic rf);
    @(posedge mclk);
    op <= o; word_size <= w; use_imm <= i; dest_register <= d; source_register <= s; imm <= m;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    #1;
    chk("done", done, 1'b1);
    chk("result_we", result_we, we);
    chk("refused", refused, rf);
    chk("result", result, r);
    nwb = nwb + we;
  endtask

  // Flag port write and read, one strobe cycle each.
  task bw(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_addr <= a; bus_wdata <= d; bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask
  task br(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    bus_addr <= a; bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask

  // Watchdog against a hung run.
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    wrap_up;
  end

  initial begin
    {start, word_size, use_imm, step_two, bus_wr, bus_rd} = '0;
    op = op_add; dest_register = '0; source_register = '0; imm = '0; bus_addr = '0; bus_wdata = '0;
    err_count = 0; tests_run = 0; nwb = '0; reset = 1'b1;
    clk_en = 1'b1;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    go(op_add, 0, 0, 16'h007F, 16'h0001, 0, 16'h0080, 1, 0);
    chk("flags", condition_flags_register, 8'h2A);
    chk("result_word", result_word, 1'b0);
    go(op_add, 0, 1, 16'h00F0, 0, 8'h20, 16'h0010, 1, 0);
    chk("flags", condition_flags_register, 8'h01);
    go(op_add, 1, 0, 16'h1234, 16'h1111, 0, 16'h2345, 1, 0);
    chk("result_word", result_word, 1'b1);
    go(op_sub, 1, 0, 16'h1000, 16'h0001, 0, 16'h0FFF, 1, 0);
    go(op_sub, 0, 1, 16'h0033, 0, 8'h01, 16'h0FFF, 0, 1);
    go(op_add, 1, 1, 16'h0033, 0, 8'h01, 16'h0FFF, 0, 1);
    go(compare_op, 1, 1, 16'h0033, 0, 8'h01, 16'h0FFF, 0, 1);
    go(compare_op, 0, 1, 16'h0055, 0, 8'h55, 16'h0FFF, 0, 0);
    chk("flags", condition_flags_register, 8'h04);
    bw(4'h0, 8'h01);
    go(add_with_carry_op, 0, 1, 16'h0010, 0, 8'h20, 16'h0031, 1, 0);
    bw(4'h0, 8'h01);
    go(subtract_with_carry_op, 0, 0, 16'h0031, 16'h0010, 0, 16'h0020, 1, 0);
    go(count_down_op, 0, 0, 16'h0000, 0, 0, 16'h00FF, 1, 0);
    go(count_up_op, 0, 0, 16'h00FF, 0, 0, 16'h0000, 1, 0);
    @(posedge mclk);
    step_two <= 1'b1;
    go(word_step_subtract_op, 0, 0, 16'h0001, 0, 0, 16'hFFFF, 1, 0);
    @(posedge mclk);
    step_two <= 1'b0;
    go(word_step_add_op, 0, 0, 16'hFFFF, 0, 0, 16'h0000, 1, 0);
    chk("result_word", result_word, 1'b1);
    go(op_add, 0, 0, 16'h0015, 16'h0027, 0, 16'h003C, 1, 0);
    go(bcd_adjust_after_add, 0, 0, 16'h003C, 0, 0, 16'h0042, 1, 0);
    go(op_sub, 0, 0, 16'h0042, 16'h0015, 0, 16'h002D, 1, 0);
    go(bcd_adjust_after_sub, 0, 0, 16'h002D, 0, 0, 16'h0027, 1, 0);
    go(unsigned_multiply_8x8, 0, 0, 16'h00FF, 16'h00FF, 0, 16'hFE01, 1, 0);
    chk("result_word", result_word, 1'b1);
    go(unsigned_divide_16by8, 0, 0, 16'h1234, 16'h0056, 0, 16'h1036, 1, 0);
    go(unsigned_divide_16by8, 0, 0, 16'h1234, 16'h0000, 0, 16'h1036, 0, 0);
    go(twos_complement_op, 0, 0, 16'h0001, 0, 0, 16'h00FF, 1, 0);
    // A low clock enable must swallow a request and freeze done, the result and the flags.
    @(posedge mclk);
    clk_en <= 1'b0;
    op <= op_not;
    dest_register <= 16'h00F0;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    #1 chk("frozen_done", done, 1'b0);
    chk("frozen_result", result, 16'h00FF);
    chk("frozen_flags", condition_flags_register, 8'h29);
    @(posedge mclk);
    clk_en <= 1'b1;
    // Register forms of the four logic operations, then one immediate form.
    for (int k = 0; k < 4; k++) begin
      go(lg_op[k], 0, 0, 16'h00C3, 16'h005A, 0, {8'h00, lg_res[k]}, 1, 0);
    end
    go(op_or, 0, 1, 16'h0003, 0, 8'h30, 16'h0033, 1, 0);
    // The last two entries rely on the carry left by the entry before them.
    for (int k = 0; k < 8; k++) begin
      go(sh_op[k], 0, 0, {8'h00, sh_in[k]}, 0, 0, {8'h00, sh_res[k]}, 1, 0);
      chk("carry", condition_flags_register[FLAG_C_POS], sh_c[k]);
    end
    bw(4'h0, 8'h2F);
    br(4'h0, q);
    chk("flag_read", q, 8'h2F);
    br(4'h3, q);
    chk("unmapped_read", q, 8'h00);
    @(posedge mclk);
    #1 chk("writebacks", wb_count, nwb);
    wrap_up;
  end
endmodule // tb
